// ---- hw/idx_engine.sv ----
`timescale 1ns/100ps
`include "idx_cfg.svh"
module idx_engine #(
  parameter int N = 8
) (
  input  wire logic           clk_sys,
  input  wire logic           resetn,
  input  wire logic           engine_enable,
  input  wire logic [N-1:0]   irq_req,
  input  wire logic [3*N-1:0] irq_level,
  output logic [N-1:0]        irq_claim,
  input  wire logic           hp_irq_busy,
  input  wire logic [31:0]    vector_base,
  output logic                mem_req,
  output logic                mem_we,
  output logic                mem_word,
  output logic [31:0]         mem_addr,
  output logic [15:0]         mem_wdata,
  input  wire logic           mem_ready,
  input  wire logic [15:0]    mem_rdata,
  output logic                busy,
  output logic                xfer_pulse,
  output logic                end_irq,
  output logic [31:0]         end_irq_addr,
  output logic                end_routine_go,
  output logic [31:0]         est_cycles
);
  localparam int SW = (N > 1) ? $clog2(N) : 1;

  idx_pkg::idx_state_t st;
  logic [15:0] mod_w, cnt, cnt0, sadr, oadr, dadr, src_val;
  logic [31:0] idx_base, vec_addr, cadr, iadr;
  logic [4:0]  w;
  logic [2:0]  moves;
  logic [1:0]  wb;
  logic        pushed;
  logic [3:0]  eot_tmr;

  logic        is_word, src_mem, src_inc, dst_inc, multi, add_op, burst, end_en, chain;
  logic [15:0] step, dmask, rd_m;
  logic [4:0]  last_w, off, k2, ki;
  logic        ack, fire;
  logic        want_bus, nx_we, nx_word;
  logic [31:0] nx_addr;
  logic [15:0] nx_wdata;
  logic        buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [15:0] buf_out_data;

  idx_req_if #(.SW(SW)) rq ();

  idx_pick #(.N(N), .SW(SW)) u_pick (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .engine_enable (engine_enable),
    .irq_req       (irq_req),
    .irq_level     (irq_level),
    .irq_claim     (irq_claim),
    .rq            (rq.pick)
  );

  // operand buffer between the read side and the destination write
  idx_buf #(.W(16), .D(2)) u_buf (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (src_val),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // control word fields
  assign is_word = mod_w[`IDX_MOD_WORD];
  assign src_mem = mod_w[`IDX_MOD_SRCMEM];
  assign src_inc = mod_w[`IDX_MOD_SRCINC];
  assign dst_inc = mod_w[`IDX_MOD_DSTINC];
  assign multi   = mod_w[`IDX_MOD_MULTI];
  assign add_op  = mod_w[`IDX_MOD_ADD];
  assign burst   = mod_w[`IDX_MOD_BURST];
  assign end_en  = mod_w[`IDX_MOD_ENDIRQ];
  assign chain   = mod_w[`IDX_MOD_CHAIN];

  assign step  = is_word ? 16'h0002 : 16'h0001;
  assign dmask = is_word ? 16'hffff : 16'h00ff;
  assign rd_m  = mem_rdata & dmask;
  assign ack   = mem_req && mem_ready;

  // index layout: mod, count, src, [opr], dst, [chain x2], [routine x2]
  assign last_w = 5'h3 + 5'(add_op) + (chain ? 5'h2 : 5'h0) + (end_en ? 5'h2 : 5'h0);
  assign off    = w - 5'h2;
  assign k2     = off - 5'h1 - 5'(add_op);
  assign ki     = k2 - (chain ? 5'h3 : 5'h1);

  // engine only starts when no higher priority sequence is running
  assign rq.ready = (st == idx_pkg::st_idle) && !hp_irq_busy && engine_enable;
  assign busy     = (st != idx_pkg::st_idle);

  assign buf_in_valid  = (st == idx_pkg::st_dst) && !pushed;
  assign buf_out_ready = (st == idx_pkg::st_dst) && !mem_req;

  // end interrupt only once the count has run out
  assign fire = ack && end_en && !multi &&
                ((st == idx_pkg::st_wb && wb == 2'h3 && cnt == 16'h0000 && !chain) ||
                 (st == idx_pkg::st_chn && wb == 2'h1));

  // bus address and data wanted by the current state
  always_comb begin
    want_bus = 1'b1;
    nx_we    = 1'b0;
    nx_word  = 1'b1;
    nx_addr  = 32'h0000_0000;
    nx_wdata = 16'h0000;
    case (st)
      idx_pkg::st_vec: begin
        nx_addr = vec_addr + {30'h0, wb[0], 1'b0};
      end
      idx_pkg::st_load: begin
        nx_addr = idx_base + {26'h0, w, 1'b0};
      end
      idx_pkg::st_src: begin
        want_bus = src_mem;
        nx_word  = is_word;
        nx_addr  = {16'h0000, sadr};
      end
      idx_pkg::st_opr: begin
        nx_word = is_word;
        nx_addr = {16'h0000, oadr};
      end
      idx_pkg::st_dst: begin
        want_bus = buf_out_valid;
        nx_we    = 1'b1;
        nx_word  = is_word;
        nx_addr  = {16'h0000, dadr};
        nx_wdata = buf_out_data;
      end
      idx_pkg::st_wb: begin
        // write the running count and addresses back for the next request
        nx_we = 1'b1;
        want_bus = !(wb == 2'h2 && !add_op);
        case (wb)
          2'h0: begin
            nx_addr  = idx_base + 32'h2;
            nx_wdata = cnt;
          end
          2'h1: begin
            nx_addr  = idx_base + 32'h4;
            nx_wdata = sadr;
          end
          2'h2: begin
            nx_addr  = idx_base + 32'h6;
            nx_wdata = oadr;
          end
          default: begin
            nx_addr  = idx_base + (add_op ? 32'h8 : 32'h6);
            nx_wdata = dadr;
          end
        endcase
      end
      idx_pkg::st_chn: begin
        nx_we    = 1'b1;
        nx_addr  = vec_addr + {30'h0, wb[0], 1'b0};
        nx_wdata = wb[0] ? cadr[31:16] : cadr[15:0];
      end
      default: begin
        want_bus = 1'b0;
      end
    endcase
  end

  // bus master: one access outstanding, held until ready
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_word  <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 16'h0000;
    end else if (ack) begin
      mem_req <= 1'b0;
    end else if (!mem_req && want_bus) begin
      mem_req   <= 1'b1;
      mem_we    <= nx_we;
      mem_word  <= nx_word;
      mem_addr  <= nx_addr;
      mem_wdata <= nx_wdata;
    end
  end

  // sequencer and index fields
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st       <= idx_pkg::st_idle;
      mod_w    <= 16'h0000;
      cnt      <= 16'h0000;
      cnt0     <= 16'h0000;
      sadr     <= 16'h0000;
      oadr     <= 16'h0000;
      dadr     <= 16'h0000;
      src_val  <= 16'h0000;
      idx_base <= 32'h0000_0000;
      vec_addr <= 32'h0000_0000;
      cadr     <= 32'h0000_0000;
      iadr     <= 32'h0000_0000;
      w        <= 5'h00;
      moves    <= 3'h0;
      wb       <= 2'h0;
      pushed   <= 1'b0;
    end else begin
      case (st)
        idx_pkg::st_idle: begin
          if (rq.valid && rq.ready) begin
            vec_addr <= vector_base + {{(30-SW){1'b0}}, rq.src, 2'b00};
            wb       <= 2'h0;
            st       <= idx_pkg::st_vec;
          end
        end
        idx_pkg::st_vec: begin
          // vector is read afresh, so a chain rewrite takes effect next time
          if (ack) begin
            if (wb[0]) begin
              idx_base[31:16] <= mem_rdata;
              w  <= 5'h00;
              st <= idx_pkg::st_load;
            end else begin
              idx_base[15:0] <= mem_rdata;
              wb <= 2'h1;
            end
          end
        end
        idx_pkg::st_load: begin
          if (ack) begin
            if (w == 5'h00) begin
              mod_w <= mem_rdata;
              moves <= mem_rdata[`IDX_MOD_TALLY +: 3];
            end else if (w == 5'h01) begin
              cnt  <= mem_rdata;
              cnt0 <= mem_rdata;
            end else if (multi) begin
              if (w[0]) begin
                dadr <= mem_rdata;
              end else begin
                sadr <= mem_rdata;
              end
            end else if (off == 5'h00) begin
              sadr <= mem_rdata;
            end else if (add_op && off == 5'h01) begin
              oadr <= mem_rdata;
            end else if (k2 == 5'h00) begin
              dadr <= mem_rdata;
            end else if (chain && k2 == 5'h01) begin
              cadr[15:0] <= mem_rdata;
            end else if (chain && k2 == 5'h02) begin
              cadr[31:16] <= mem_rdata;
            end else if (ki == 5'h00) begin
              iadr[15:0] <= mem_rdata;
            end else begin
              iadr[31:16] <= mem_rdata;
            end
            if (w == 5'h01 && mem_rdata == 16'h0000) begin
              st <= idx_pkg::st_idle;
            end else if (w != 5'h00 && (multi ? (w >= 5'h03 && w[0]) : (w == last_w))) begin
              pushed <= 1'b0;
              st     <= idx_pkg::st_src;
            end else begin
              w <= w + 5'h01;
            end
          end
        end
        idx_pkg::st_src: begin
          if (!src_mem) begin
            src_val <= sadr & dmask;
            st      <= add_op ? idx_pkg::st_opr : idx_pkg::st_dst;
          end else if (ack) begin
            src_val <= rd_m;
            st      <= add_op ? idx_pkg::st_opr : idx_pkg::st_dst;
          end
        end
        idx_pkg::st_opr: begin
          if (ack) begin
            src_val <= (src_val + rd_m) & dmask;
            st      <= idx_pkg::st_dst;
          end
        end
        idx_pkg::st_dst: begin
          if (buf_in_valid && buf_in_ready) begin
            pushed <= 1'b1;
          end
          if (ack) begin
            pushed <= 1'b0;
            if (src_inc && !multi) begin
              sadr <= sadr + step;
              oadr <= add_op ? oadr + step : oadr;
            end
            if (dst_inc && !multi) begin
              dadr <= dadr + step;
            end
            if (multi) begin
              if (moves > 3'h1) begin
                moves <= moves - 3'h1;
                w     <= w + 5'h01;
                st    <= idx_pkg::st_load;
              end else begin
                st <= idx_pkg::st_idle;
              end
            end else begin
              cnt <= cnt - 16'h0001;
              if (burst && cnt != 16'h0001) begin
                st <= idx_pkg::st_src;
              end else begin
                wb <= 2'h0;
                st <= idx_pkg::st_wb;
              end
            end
          end
        end
        idx_pkg::st_wb: begin
          if (ack || (wb == 2'h2 && !add_op)) begin
            wb <= wb + 2'h1;
            if (wb == 2'h3) begin
              wb <= 2'h0;
              st <= (cnt == 16'h0000 && chain) ? idx_pkg::st_chn : idx_pkg::st_idle;
            end
          end
        end
        idx_pkg::st_chn: begin
          if (ack) begin
            wb <= 2'h1;
            if (wb[0]) begin
              st <= idx_pkg::st_idle;
            end
          end
        end
        default: begin
          st <= idx_pkg::st_idle;
        end
      endcase
    end
  end

  // event outputs and routine start delay
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xfer_pulse     <= 1'b0;
      end_irq        <= 1'b0;
      end_irq_addr   <= 32'h0000_0000;
      end_routine_go <= 1'b0;
      eot_tmr        <= 4'h0;
    end else begin
      xfer_pulse     <= ack && (st == idx_pkg::st_dst);
      end_irq        <= fire;
      end_routine_go <= (eot_tmr == 4'h1);
      if (fire) begin
        end_irq_addr <= iadr;
        eot_tmr      <= `IDX_EOT_LAT;
      end else if (eot_tmr != 4'h0) begin
        eot_tmr <= eot_tmr - 4'h1;
      end
    end
  end

  // execution budget, reported for the index last loaded
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      est_cycles <= 32'h0000_0000;
    end else if (multi) begin
      est_cycles <= `IDX_T_MULTI_BASE + 32'(moves_k()) *
                    32'(`IDX_T_MULTI_STEP + 8'(!src_inc) + 8'(!dst_inc));
    end else begin
      est_cycles <= `IDX_T_BASE + 32'(per_xfer()) * (burst ? {16'h0000, cnt0} : 32'h1) +
                    ((cnt0 >= 16'h0002) ? 32'(`IDX_T_LINK + (chain ? `IDX_T_CHAIN : 8'h0)) : 32'h0);
    end
  end

  function automatic logic [2:0] moves_k();
    return mod_w[`IDX_MOD_TALLY +: 3];
  endfunction

  // a memory source saves one cycle, fixed addresses cost one each
  function automatic logic [7:0] per_xfer();
    logic [7:0] d;
    d = add_op ? (src_inc ? `IDX_T_ADD_INC : `IDX_T_ADD_FIX) : 8'h0;
    return `IDX_T_STEP - 8'(src_mem) + 8'(!src_inc) + 8'(!dst_inc) + d;
  endfunction
endmodule

// ---- hw/idx_cfg.svh ----
`ifndef IDX_CFG_SVH
`define IDX_CFG_SVH
// Functional notes
// - zero remaining count means no transfer
// - burst bit picks single or burst
// - single mode moves one unit per request
// - incrementing addresses advance after each transfer
// - step one byte or two, wrap 64K
// - every transfer decrements remaining count; multi-move leaves it unchanged
// - single mode end interrupt only at zero
// - burst runs back to back until zero
// - no new requests taken during burst
// - multi-move does tally field moves, 1..7
// - multi-move address pairs follow count word
// - index found through requester vector each time
// - chain writes next index pointer to vector
// - end interrupt together with vector rewrite
// - end interrupt carries routine pointer at zero
// - multi-move budget 21 plus (11+b+c)*k
// - other budget 6+(26+a+b+c+d)*m+(4+e)*n
// - terms a, b, c from source, increments
// - terms d from add mode, e chaining
// - terms m from burst, n from count
// - routine starts eighth cycle after end
// - higher priority interrupt runs first
// - level 7 request starts engine, not interrupt

// index control word fields
`define IDX_MOD_WORD   0
`define IDX_MOD_SRCMEM 1
`define IDX_MOD_SRCINC 2
`define IDX_MOD_DSTINC 3
`define IDX_MOD_TALLY  4
`define IDX_MOD_MULTI  7
`define IDX_MOD_ADD    8
`define IDX_MOD_BURST  9
`define IDX_MOD_ENDIRQ 10
`define IDX_MOD_CHAIN  11

`define IDX_LVL_ENGINE 3'h7
`define IDX_EOT_LAT    4'h8

// execution budget terms in cycles
`define IDX_T_MULTI_BASE 32'h15
`define IDX_T_MULTI_STEP 8'h0b
`define IDX_T_BASE       32'h6
`define IDX_T_STEP       8'h1a
`define IDX_T_LINK       8'h4
`define IDX_T_CHAIN      8'h4
`define IDX_T_ADD_FIX    8'h7
`define IDX_T_ADD_INC    8'h8
`endif

// ---- hw/idx_pkg.sv ----
package idx_pkg;
  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_vec  = 8'h02,
    st_load = 8'h04,
    st_src  = 8'h08,
    st_opr  = 8'h10,
    st_dst  = 8'h20,
    st_wb   = 8'h40,
    st_chn  = 8'h80
  } idx_state_t;
endpackage

// ---- hw/idx_req_if.sv ----
`timescale 1ns/100ps
interface idx_req_if #(parameter int SW = 3);
  logic          valid;
  logic          ready;
  logic [SW-1:0] src;
  modport pick (output valid, output src, input ready);
  modport eng  (input valid, input src, output ready);
endinterface

// ---- hw/idx_pick.sv ----
`timescale 1ns/100ps
`include "idx_cfg.svh"
module idx_pick #(
  parameter int N  = 8,
  parameter int SW = 3
) (
  input  wire logic           clk_sys,
  input  wire logic           resetn,
  input  wire logic           engine_enable,
  input  wire logic [N-1:0]   irq_req,
  input  wire logic [3*N-1:0] irq_level,
  output logic [N-1:0]        irq_claim,
  idx_req_if.pick             rq
);
  logic [N-1:0] pend;

  // per source: claim and pending flag; a new request beats the grant clear
  for (genvar i = 0; i < N; i++) begin : g_src
    assign irq_claim[i] = engine_enable && (irq_level[3*i +: 3] == `IDX_LVL_ENGINE);
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pend[i] <= 1'b0;
      end else if (irq_req[i] && irq_claim[i]) begin
        pend[i] <= 1'b1;
      end else if (rq.valid && rq.ready && rq.src == SW'(i)) begin
        pend[i] <= 1'b0;
      end
    end
  end

  // lowest numbered pending source wins
  always_comb begin
    rq.valid = |pend;
    rq.src   = '0;
    for (int j = N - 1; j >= 0; j--) begin
      if (pend[j]) begin
        rq.src = SW'(j);
      end
    end
  end
endmodule

// ---- hw/idx_buf.sv ----
`timescale 1ns/100ps
module idx_buf #(
  parameter int W = 16,
  parameter int D = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_p, rd_p;
  logic [PW:0]   fill;
  logic          push, pop;

  assign in_ready  = (fill != (PW+1)'(D));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_p];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers wrap at the depth, not at a power of two
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_p <= '0;
      rd_p <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_p <= (wr_p == PW'(D - 1)) ? '0 : wr_p + 1'b1;
      end
      if (pop) begin
        rd_p <= (rd_p == PW'(D - 1)) ? '0 : rd_p + 1'b1;
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage needs no reset; fill guards every read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_p] <= in_data;
    end
  end
endmodule

// ---- verif/idx_engine_chk.sv ----
`timescale 1ns/100ps
module idx_engine_chk #(
  parameter int N = 8
) (
  input wire logic           clk_sys,
  input wire logic           resetn,
  input wire logic           engine_enable,
  input wire logic [N-1:0]   irq_req,
  input wire logic [3*N-1:0] irq_level,
  input wire logic [N-1:0]   irq_claim,
  input wire logic           hp_irq_busy,
  input wire logic [31:0]    vector_base,
  input wire logic           mem_req,
  input wire logic           mem_we,
  input wire logic           mem_word,
  input wire logic [31:0]    mem_addr,
  input wire logic [15:0]    mem_wdata,
  input wire logic           mem_ready,
  input wire logic [15:0]    mem_rdata,
  input wire logic           busy,
  input wire logic           xfer_pulse,
  input wire logic           end_irq,
  input wire logic [31:0]    end_irq_addr,
  input wire logic           end_routine_go,
  input wire logic [31:0]    est_cycles
);
  logic [N-1:0] exp_claim;

  // expected claim per source from enable and level field
  always_comb begin
    for (int i = 0; i < N; i++) begin
      exp_claim[i] = engine_enable && (irq_level[3*i +: 3] == 3'h7);
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_claim_by_level: assert property (irq_claim == exp_claim)
    else $error("claim does not follow level and enable");
  a_start_enabled: assert property ($rose(busy) |-> $past(engine_enable))
    else $error("engine started while disabled");
  a_start_after_hp: assert property ($rose(busy) |-> !$past(hp_irq_busy))
    else $error("engine started during higher priority sequence");
  a_req_held_stable: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("access changed before completion");
  a_req_drops_after: assert property (mem_req && mem_ready |=> !mem_req)
    else $error("access not released after completion");
  a_mem_only_busy: assert property (mem_req |-> busy)
    else $error("memory access while idle");
  a_end_one_cycle: assert property (end_irq |=> !end_irq)
    else $error("end interrupt longer than one cycle");
  a_routine_eighth: assert property (end_irq |-> ##8 end_routine_go)
    else $error("routine start not eight cycles after end");
  a_routine_addr_only_end: assert property ($changed(end_irq_addr) |-> end_irq)
    else $error("routine pointer changed without end interrupt");
  cover property (end_irq && busy);
endmodule

bind idx_engine idx_engine_chk #(.N(N)) i_idx_engine_chk (.*);

// ---- verif/idx_mem.sv ----
`timescale 1ns/100ps
module idx_mem (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_word,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0]  wait_cyc,
  output logic            mem_ready,
  output logic [15:0]     mem_rdata
);
  logic [7:0]  mem [0:65535];
  logic [3:0]  cnt;
  logic [15:0] a;

  assign a = mem_addr[15:0];

  // cleared ram so untouched places compare as zero
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end

  // one outstanding access, wait_cyc extra cycles before ready
  // read data is scrambled outside ready so no stale value is trusted
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_ready <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && mem_ready) begin
      mem_ready <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_we) begin
        mem[a] <= mem_wdata[7:0];
        if (mem_word) mem[a+16'h0001] <= mem_wdata[15:8];
      end
    end else if (mem_req && cnt >= wait_cyc) begin
      mem_ready <= 1'b1;
      mem_rdata <= mem_word ? {mem[a+16'h0001], mem[a]} : {8'h00, mem[a]};
    end else begin
      cnt       <= mem_req ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ---- verif/tb_idx_engine.sv ----
`timescale 1ns/100ps
module tb_idx_engine;
  localparam logic [31:0] VB = 32'h0000_fe00;
  logic        clk_sys, resetn, engine_enable, hp_irq_busy;
  logic [7:0]  irq_req, irq_claim;
  logic [23:0] irq_level;
  logic        mem_req, mem_we, mem_word, mem_ready;
  logic [31:0] mem_addr, end_irq_addr, est_cycles;
  logic [15:0] mem_wdata, mem_rdata;
  logic        busy, xfer_pulse, end_irq, end_routine_go;
  logic [3:0]  wait_cyc;
  int          err_total, checks_done, xfers, ends, cyc;

  idx_engine #(.N(8)) i_idx_engine (.clk_sys(clk_sys), .resetn(resetn), .engine_enable(engine_enable),
    .irq_req(irq_req), .irq_level(irq_level), .irq_claim(irq_claim), .hp_irq_busy(hp_irq_busy),
    .vector_base(VB), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy(busy),
    .xfer_pulse(xfer_pulse), .end_irq(end_irq), .end_irq_addr(end_irq_addr),
    .end_routine_go(end_routine_go), .est_cycles(est_cycles));
  idx_mem i_idx_mem (.clk_sys(clk_sys), .resetn(resetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cyc(wait_cyc),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  // clock and event tallies; ceiling far above the expected run
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (xfer_pulse === 1'b1) xfers++;
    if (end_irq === 1'b1) ends++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic poke(input logic [15:0] a, input logic [15:0] v);
    i_idx_mem.mem[a] = v[7:0];
    i_idx_mem.mem[a+16'h0001] = v[15:8];
  endtask
  function automatic logic [15:0] peek(input logic [15:0] a);
    return {i_idx_mem.mem[a+16'h0001], i_idx_mem.mem[a]};
  endfunction
  // index table of eight words, then the source vector pointed at it
  task automatic put(input logic [15:0] a, w0, w1, w2, w3, w4, w5, w6, w7);
    poke(a, w0); poke(a+16'h2, w1); poke(a+16'h4, w2); poke(a+16'h6, w3);
    poke(a+16'h8, w4); poke(a+16'ha, w5); poke(a+16'hc, w6); poke(a+16'he, w7);
    poke(VB[15:0], a);
    poke(VB[15:0]+16'h2, 16'h0000);
    xfers = 0;
    ends = 0;
  endtask
  task automatic wait_busy(input logic want, input int lim);
    for (int i = 0; i < lim && busy !== want; i++) @(negedge clk_sys);
  endtask
  task automatic fire(input int s);
    @(negedge clk_sys);
    irq_req[s] = 1'b1;
    @(negedge clk_sys);
    irq_req[s] = 1'b0;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 2000);
    // end pulse comes out on the edge that returns to idle, let the tallies catch it
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic t_zero;
    put(16'h1000, 16'h040d, 16'h0000, 16'h2000, 16'h3300, 16'h0, 16'h0, 16'h0, 16'h0);
    fire(0);
    chk(32'h0, xfers);
    chk(32'h0, ends);
    chk(32'h0, peek(16'h3300));
    $display("test zero count done");
  endtask
  task automatic t_single;
    poke(16'h2000, 16'ha55a);
    poke(16'h2002, 16'h1234);
    put(16'h1100, 16'h040f, 16'h0002, 16'h2000, 16'h3000, 16'h7700, 16'h0001, 16'h0, 16'h0);
    fire(0);
    chk(32'h1, xfers);
    chk(32'h0, ends);
    chk(32'ha55a, peek(16'h3000));
    chk(32'h1, peek(16'h1102));
    chk(32'h2002, peek(16'h1104));
    chk(32'h3002, peek(16'h1106));
    chk(32'd35, est_cycles);
    wait_cyc = 4'h3;
    fire(0);
    wait_cyc = 4'h0;
    chk(32'h1234, peek(16'h3002));
    chk(32'h1, ends);
    chk(32'h0001_7700, end_irq_addr);
    $display("test single done");
  endtask
  task automatic t_burst;
    poke(16'h4000, 16'h2211);
    poke(16'h4002, 16'h0033);
    put(16'h1200, 16'h020e, 16'h0003, 16'h4000, 16'hfffe, 16'h0, 16'h0, 16'h0, 16'h0);
    poke(VB[15:0]+16'h4, 16'h1000);
    poke(VB[15:0]+16'h6, 16'h0000);
    hp_irq_busy = 1'b1;
    @(negedge clk_sys);
    irq_req[0] = 1'b1;
    @(negedge clk_sys);
    irq_req[0] = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk(32'h0, busy);
    hp_irq_busy = 1'b0;
    wait_busy(1'b1, 10);
    repeat (6) @(negedge clk_sys);
    irq_req[1] = 1'b1;
    @(negedge clk_sys);
    irq_req[1] = 1'b0;
    wait_busy(1'b0, 2000);
    chk(32'h3, xfers);
    chk(32'h2211, peek(16'hfffe));
    chk(32'h33, i_idx_mem.mem[16'h0000]);
    chk(32'h0001, peek(16'h1206));
    chk(32'h0, peek(16'h1202));
    wait_busy(1'b1, 5);
    chk(32'h1, busy);
    wait_busy(1'b0, 2000);
    $display("test burst done");
  endtask
  // plain memory copy only, as multi-move demands of software
  task automatic t_multi;
    put(16'h1300, 16'h00a3, 16'h0005, 16'h2000, 16'h3200, 16'h2002, 16'h3204, 16'h0, 16'h0);
    wait_cyc = 4'h2;
    fire(0);
    wait_cyc = 4'h0;
    chk(32'h2, xfers);
    chk(32'ha55a, peek(16'h3200));
    chk(32'h1234, peek(16'h3204));
    chk(32'h5, peek(16'h1302));
    chk(32'd47, est_cycles);
    $display("test multi done");
  endtask
  task automatic t_chain;
    put(16'h1400, 16'h0c01, 16'h0001, 16'hbeef, 16'h3100, 16'h1500, 16'h0000, 16'h7800, 16'h0002);
    fire(0);
    chk(32'hbeef, peek(16'h3100));
    chk(32'h1, ends);
    chk(32'h0002_7800, end_irq_addr);
    chk(32'h1500, peek(VB[15:0]));
    poke(16'h1500, 16'h0001);
    poke(16'h1502, 16'h0001);
    poke(16'h1504, 16'h5678);
    poke(16'h1506, 16'h3102);
    fire(0);
    chk(32'h5678, peek(16'h3102));
    $display("test chain done");
  endtask
  // immediate plus memory word, both addresses fixed
  task automatic t_add;
    put(16'h1600, 16'h0101, 16'h0001, 16'h0005, 16'h2000, 16'h3400, 16'h0, 16'h0, 16'h0);
    fire(0);
    chk(32'ha55f, peek(16'h3400));
    chk(32'h0, peek(16'h1602));
    chk(32'h2000, peek(16'h1606));
    chk(32'h3400, peek(16'h1608));
    chk(32'd41, est_cycles);
    $display("test add done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    engine_enable = 1'b1;
    hp_irq_busy = 1'b0;
    irq_req = 8'h00;
    irq_level = 24'h00003f;
    wait_cyc = 4'h0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    t_zero();
    t_single();
    t_burst();
    t_multi();
    t_chain();
    t_add();
    summarize();
  end
endmodule
